// file: hdl/uden_core.sv
// uden_core: data port, receive fifo and interrupt enable/output logic of one channel
// assumes framing, line and modem status logic outside, on the same clock
`timescale 1ns/1ps
module uden_core
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [4:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic [2:0] rx_err_in,
  input wire logic overrun_in,
  input wire logic tx_taken_in,
  input wire logic modem_pend_in,
  input wire logic xoff_seen_in,
  input wire logic cts_pin_in,
  input wire logic rts_state_in,
  output logic [7:0] tx_byte_out,
  output logic tx_full_out,
  output logic interrupt_output,
  output logic sleep_out
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] rxq [0:uden_pkg::FIFO_DEPTH-1];
  logic [2:0] errq [0:uden_pkg::FIFO_DEPTH-1];
  logic [7:0] txhold_r;
  logic tx_full_r, tx_full_nxt;
  logic [uden_pkg::PTR_W-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [7:0] mask_r, mask_nxt, enh_r, enh_nxt;
  logic [3:0] line_r, line_nxt;
  logic thre_pend_r, thre_pend_nxt;
  logic xoff_r, xoff_nxt, flow_r, flow_nxt;
  logic [15:0] tcnt_r, tcnt_nxt;
  logic tout_r, tout_nxt;
  logic cts_s1_r, cts_s2_r, cts_d_r, rts_d_r;
  logic [31:0] prdata_r, prdata_nxt;
  logic ready_r, ready_nxt, irq_r, irq_nxt, sleep_r, sleep_nxt;
  logic acc, wr, rd;
  logic [2:0] idx;
  logic empty, full, pop, push;
  logic [5:0] ident;
  logic enh;
  logic flow_set;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] slot(input logic [uden_pkg::PTR_W-1:0] p);
    slot = p[3:0];
  endfunction

  assign acc = psel_in & penable_in & ~ready_r;
  assign wr = acc & pwrite_in;
  assign rd = acc & ~pwrite_in;
  assign idx = paddr_in[4:2];
  assign empty = (wp_r == rp_r);
  assign full = (wp_r[3:0] == rp_r[3:0]) && (wp_r[4] != rp_r[4]);
  assign pop = rd && idx == uden_pkg::DATA_IDX && !empty;
  assign push = rx_valid_in && !full;
  assign enh = enh_r[uden_pkg::ENH_BIT];
  // edges of cts and rts that latch while their own bit is set
  assign flow_set = (cts_s2_r & ~cts_d_r & mask_r[uden_pkg::MB_CTS])
                  | (rts_state_in & ~rts_d_r & mask_r[uden_pkg::MB_RTS]);

  // prioritised identification of enabled pending sources
  always_comb
  begin
    ident = uden_pkg::ID_NONE;
    if (mask_r[uden_pkg::MB_CTS] | mask_r[uden_pkg::MB_RTS])
      if (enh && flow_r) ident = uden_pkg::ID_FLOW;
    if (mask_r[uden_pkg::MB_XOFF] && enh && xoff_r) ident = uden_pkg::ID_XOFF;
    if (mask_r[uden_pkg::MB_MODEM] && modem_pend_in) ident = uden_pkg::ID_MODEM;
    if (mask_r[uden_pkg::MB_TXEMPTY] && thre_pend_r) ident = uden_pkg::ID_TXEMPTY;
    if (mask_r[uden_pkg::MB_RXDATA] && !empty) ident = uden_pkg::ID_RXDATA;
    if (mask_r[uden_pkg::MB_RXDATA] && tout_r) ident = uden_pkg::ID_TOUT;
    if (mask_r[uden_pkg::MB_LINE] && |line_r) ident = uden_pkg::ID_LINE;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    wp_nxt = wp_r + uden_pkg::PTR_W'(push);
    rp_nxt = rp_r + uden_pkg::PTR_W'(pop);
    mask_nxt = mask_r;
    enh_nxt = enh_r;
    tx_full_nxt = tx_full_r & ~tx_taken_in;
    thre_pend_nxt = thre_pend_r | (tx_full_r & tx_taken_in);
    // line flags: overrun at once, others when the bad byte pops
    line_nxt = line_r;
    if (overrun_in) line_nxt[0] = 1'b1;
    if (pop) line_nxt[3:1] = line_r[3:1] | errq[slot(rp_r)];
    xoff_nxt = xoff_r | xoff_seen_in;
    flow_nxt = flow_r | flow_set;
    // time-out counter runs while data waits untouched
    tcnt_nxt = tcnt_r;
    tout_nxt = tout_r;
    if (empty || push || pop)
    begin
      tcnt_nxt = 16'h0000;
      if (pop) tout_nxt = 1'b0;
    end
    else if (tcnt_r == 16'(uden_pkg::TOUT_CYC - 1))
      tout_nxt = 1'b1;
    else
      tcnt_nxt = tcnt_r + 16'h0001;
    prdata_nxt = uden_pkg::UNMAPPED_VAL;
    if (wr)
    begin
      case (idx)
        uden_pkg::DATA_IDX:
        begin
          tx_full_nxt = 1'b1;
          thre_pend_nxt = 1'b0;
        end
        uden_pkg::MASK_IDX: mask_nxt = pwdata_in[7:0];
        uden_pkg::ENH_IDX: enh_nxt = pwdata_in[7:0];
        default: ;
      endcase
    end
    if (rd)
    begin
      case (idx)
        uden_pkg::DATA_IDX: prdata_nxt = {24'h000000, rxq[slot(rp_r)]};
        uden_pkg::MASK_IDX: prdata_nxt = {24'h000000, mask_r};
        uden_pkg::ENH_IDX: prdata_nxt = {24'h000000, enh_r};
        uden_pkg::LINE_IDX:
        begin
          prdata_nxt = {24'h000000, 3'h0, line_r, ~empty};
          line_nxt = 4'h0;
        end
        uden_pkg::IDENT_IDX:
        begin
          prdata_nxt = {26'h0000000, ident};
          if (ident == uden_pkg::ID_TXEMPTY) thre_pend_nxt = 1'b0;
          xoff_nxt = 1'b0;
          flow_nxt = flow_set; // set wins over the read clear
        end
        uden_pkg::STAT_IDX: prdata_nxt = {24'h000000, 2'h0, tout_r, thre_pend_r, tx_full_r, full, empty, irq_r};
        default: ;
      endcase
      if (overrun_in && idx == uden_pkg::LINE_IDX) line_nxt[0] = 1'b1; // set wins
      if (xoff_seen_in) xoff_nxt = 1'b1;
    end
    ready_nxt = acc;
    irq_nxt = (ident != uden_pkg::ID_NONE);
    sleep_nxt = mask_r[uden_pkg::MB_SLEEP] & enh;
  end

  // ---------------------------------------------------------------
  // registers with reset, except the data storage
  // ---------------------------------------------------------------
  // bus answer: read data and the one-cycle ready
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      prdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
    end
    else
    begin
      prdata_r <= prdata_nxt;
      ready_r <= ready_nxt;
    end
  end

  // enables: interrupt mask and enhanced control
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      mask_r <= uden_pkg::MASK_RST;
      enh_r <= uden_pkg::ENH_RST;
    end
    else
    begin
      mask_r <= mask_nxt;
      enh_r <= enh_nxt;
    end
  end

  // receive fifo pointers; the stored bytes live apart
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // pending flags of the interrupt sources
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tx_full_r <= 1'b0;
      thre_pend_r <= 1'b0;
      line_r <= 4'h0;
      xoff_r <= 1'b0;
      flow_r <= 1'b0;
    end
    else
    begin
      tx_full_r <= tx_full_nxt;
      thre_pend_r <= thre_pend_nxt;
      line_r <= line_nxt;
      xoff_r <= xoff_nxt;
      flow_r <= flow_nxt;
    end
  end

  // receive time-out counter
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      tcnt_r <= 16'h0000;
      tout_r <= 1'b0;
    end
    else
    begin
      tcnt_r <= tcnt_nxt;
      tout_r <= tout_nxt;
    end
  end

  // cts pin synchroniser and edge history of cts and rts
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cts_s1_r <= 1'b0;
      cts_s2_r <= 1'b0;
      cts_d_r <= 1'b0;
      rts_d_r <= 1'b0;
    end
    else
    begin
      cts_s1_r <= cts_pin_in;
      cts_s2_r <= cts_s1_r;
      cts_d_r <= cts_s2_r;
      rts_d_r <= rts_state_in;
    end
  end

  // registered interrupt and sleep outputs
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_r <= 1'b0;
      sleep_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  // data storage: not reset, survives master reset
  always_ff @(posedge clock_in)
  begin
    if (push)
    begin
      rxq[slot(wp_r)] <= rx_byte_in;
      errq[slot(wp_r)] <= rx_err_in;
    end
    if (wr && idx == uden_pkg::DATA_IDX)
      txhold_r <= pwdata_in[7:0];
  end

  assign prdata_out = prdata_r;
  assign pready_out = ready_r;
  assign pslverr_out = 1'b0;
  assign tx_byte_out = txhold_r;
  assign tx_full_out = tx_full_r;
  assign interrupt_output = irq_r;
  assign sleep_out = sleep_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  a_mask_write_takes: assert property (wr && idx == uden_pkg::MASK_IDX |=> mask_r == $past(pwdata_in[7:0]))
    else $error("mask write not stored");
  a_irq_off_masked: assert property (mask_r == 8'h00 |=> !irq_r)
    else $error("interrupt with all sources masked");
  a_irq_tracks_ident: assert property (##1 irq_r == ($past(ident) != uden_pkg::ID_NONE))
    else $error("interrupt output does not follow pending sources");
  a_sleep_needs_enh: assert property (sleep_r |-> $past(enh_r[uden_pkg::ENH_BIT]))
    else $error("sleep without enhanced bit");
  a_txw_clears_thre: assert property (wr && idx == uden_pkg::DATA_IDX |=> !thre_pend_r && tx_full_r)
    else $error("transmit write did not clear empty flag");
  a_pop_clears_tout: assert property (pop |=> !tout_r)
    else $error("time-out survived a data read");
  a_overrun_flags: assert property (overrun_in |=> line_r[0])
    else $error("overrun not flagged");
  a_line_irq_prio: assert property (mask_r[uden_pkg::MB_LINE] && |line_r |-> ident == uden_pkg::ID_LINE)
    else $error("line status not top priority");
  a_modem_ident: assert property (mask_r == 8'h08 && modem_pend_in |-> ident == uden_pkg::ID_MODEM)
    else $error("modem source not shown");
  a_answer_one: assert property (acc |=> pready_out ##1 !pready_out)
    else $error("apb answer not one cycle");
  // source gating, pending flags and sleep output
  a_flow_set_wins: assert property (flow_set |=> flow_r)
    else $error("cts or rts edge lost against a clear");
  a_xoff_set_wins: assert property (xoff_seen_in |=> xoff_r)
    else $error("xoff reception lost against a clear");
  a_enh_gates: assert property (!enh |-> ident != uden_pkg::ID_XOFF && ident != uden_pkg::ID_FLOW)
    else $error("flow source shown without enhanced bit");
  a_masked_no_ident: assert property (mask_r == 8'h00 |-> ident == uden_pkg::ID_NONE)
    else $error("masked source shown in identification");
  a_mask_holds: assert property (!(wr && idx == uden_pkg::MASK_IDX) |=> mask_r == $past(mask_r))
    else $error("mask changed without a write");
  a_sleep_follows: assert property (##1 sleep_r == $past(mask_r[uden_pkg::MB_SLEEP] && enh))
    else $error("sleep output does not follow its enables");
  // interrupt output for the transmit empty and received data sources, and the transmit empty flag
  a_tx_empty_irq: assert property (mask_r[uden_pkg::MB_TXEMPTY] && thre_pend_r |=> irq_r)
    else $error("transmit empty did not interrupt");
  a_rx_data_irq: assert property (mask_r[uden_pkg::MB_RXDATA] && !empty |=> irq_r)
    else $error("received data did not interrupt");
  a_tx_empty_sets: assert property (tx_full_r && tx_taken_in && !wr |=> thre_pend_r)
    else $error("transmit empty not flagged");
  // receive path, time-out and transmit byte
  a_pop_advances: assert property (pop |=> rp_r == $past(rp_r) + uden_pkg::PTR_W'(1))
    else $error("read pointer did not advance on a data read");
  a_full_drops: assert property (rx_valid_in && full |=> wp_r == $past(wp_r))
    else $error("byte written into a full fifo");
  a_err_on_pop: assert property (pop && errq[slot(rp_r)] != 3'h0 |=> line_r[3:1] != 3'h0)
    else $error("error of a read byte not flagged");
  a_tout_fires: assert property (tcnt_r == 16'(uden_pkg::TOUT_CYC - 1) && !(empty | push | pop) |=> tout_r)
    else $error("receive time-out did not fire");
  a_tx_data_kept: assert property (wr && idx == uden_pkg::DATA_IDX |=> txhold_r == $past(pwdata_in[7:0]))
    else $error("transmit byte not stored");
  a_line_read_clears: assert property (rd && idx == uden_pkg::LINE_IDX && !overrun_in |=> line_r == 4'h0)
    else $error("line flags survived a read");

  c_rx_pop: cover property (push ##[1:20] pop);
  c_tout_fire: cover property (tout_r && mask_r[uden_pkg::MB_RXDATA]);
  c_flow_irq: cover property (ident == uden_pkg::ID_FLOW);
  c_fifo_full: cover property (rx_valid_in && full);
  c_sleep_on: cover property (sleep_r);
endmodule

// file: hdl/uden_pkg.sv
// uden_pkg: shared constants for the serial channel data port and interrupt enable block
// assumes an apb slave with 32-bit data, one aligned word per register
package uden_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses = index * 4)
  // ---------------------------------------------------------------
  localparam logic [2:0] DATA_IDX = 3'h0;
  localparam logic [2:0] MASK_IDX = 3'h1;
  localparam logic [2:0] ENH_IDX = 3'h2;
  localparam logic [2:0] LINE_IDX = 3'h5;
  localparam logic [2:0] IDENT_IDX = 3'h6;
  localparam logic [2:0] STAT_IDX = 3'h7;
  // ---------------------------------------------------------------
  // interrupt mask field positions and the enhanced control bit
  // ---------------------------------------------------------------
  localparam int MB_RXDATA = 0;
  localparam int MB_TXEMPTY = 1;
  localparam int MB_LINE = 2;
  localparam int MB_MODEM = 3;
  localparam int MB_SLEEP = 4;
  localparam int MB_XOFF = 5;
  localparam int MB_RTS = 6;
  localparam int MB_CTS = 7;
  localparam int ENH_BIT = 4;
  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] ENH_RST = 8'h00;
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 5;
  // ---------------------------------------------------------------
  // receive time-out: 4 chars of 10 bits plus 12 bit times
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int BAUD_HZ = 115200;
  localparam int BIT_CYC = CLK_HZ / BAUD_HZ;
  localparam int TOUT_BITS = 4 * 10 + 12;
  localparam int TOUT_CYC = TOUT_BITS * BIT_CYC;
  // ---------------------------------------------------------------
  // identification codes (priority order)
  // ---------------------------------------------------------------
  localparam logic [5:0] ID_LINE = 6'h06;
  localparam logic [5:0] ID_TOUT = 6'h0C;
  localparam logic [5:0] ID_RXDATA = 6'h04;
  localparam logic [5:0] ID_TXEMPTY = 6'h02;
  localparam logic [5:0] ID_MODEM = 6'h00;
  localparam logic [5:0] ID_XOFF = 6'h10;
  localparam logic [5:0] ID_FLOW = 6'h20;
  localparam logic [5:0] ID_NONE = 6'h01;
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
endpackage

// file: verification/tb_uden_core.sv
// tb_uden_core: self-checking bench for the data port and interrupt enable block
// assumes the host model drives the apb side; the bench plays the serial-side logic
`timescale 1ns/1ps
module tb_uden_core;
  localparam logic [4:0] A_DATA = {uden_pkg::DATA_IDX, 2'b00};
  localparam logic [4:0] A_MASK = {uden_pkg::MASK_IDX, 2'b00};
  localparam logic [4:0] A_ENH = {uden_pkg::ENH_IDX, 2'b00};
  localparam logic [4:0] A_LINE = {uden_pkg::LINE_IDX, 2'b00};
  localparam logic [4:0] A_IDENT = {uden_pkg::IDENT_IDX, 2'b00};
  localparam logic [4:0] A_STAT = {uden_pkg::STAT_IDX, 2'b00};
  logic clock_in, arst_n_in, psel, penable, pwrite, pready, pslverr, irq, sleep, tx_full;
  logic [4:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic rx_valid, overrun, tx_taken, modem, xoff, cts, rts;
  logic [7:0] rx_byte, tx_byte;
  logic [2:0] rx_err;
  int error_cnt = 0;
  int compares = 0;
  // -------------------------------------------------------------
  // clock, models and device
  // -------------------------------------------------------------
  initial
  begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  uden_host host (.clock_in(clock_in), .prdata_in(prdata), .pready_in(pready), .psel_out(psel),
    .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
  uden_core DUT (.clock_in(clock_in), .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte), .rx_err_in(rx_err),
    .overrun_in(overrun), .tx_taken_in(tx_taken), .modem_pend_in(modem), .xoff_seen_in(xoff),
    .cts_pin_in(cts), .rts_state_in(rts), .tx_byte_out(tx_byte), .tx_full_out(tx_full),
    .interrupt_output(irq), .sleep_out(sleep));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic chk_irq(input logic exp);
    tick(6);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  // one-cycle pulse of a serial-side event; rts and cts stay high as levels
  task automatic pulse(input int s);
    @(posedge clock_in);
    case (s)
      0: overrun <= 1'b1;
      1: tx_taken <= 1'b1;
      2: xoff <= 1'b1;
      3: rts <= 1'b1;
      default: cts <= 1'b1;
    endcase
    @(posedge clock_in);
    overrun <= 1'b0;
    tx_taken <= 1'b0;
    xoff <= 1'b0;
  endtask
  task automatic push(input logic [7:0] b, input logic [2:0] e);
    @(posedge clock_in);
    rx_valid <= 1'b1;
    rx_byte <= b;
    rx_err <= e;
    @(posedge clock_in);
    rx_valid <= 1'b0;
  endtask
  task automatic results;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog well beyond the receive time-out wait
  initial
  begin
    #2000000;
    error_cnt++;
    results();
  end
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial
  begin
    {arst_n_in, rx_valid, overrun, tx_taken, modem, xoff, cts, rts} = 8'h00;
    rx_byte = 8'h00;
    rx_err = 3'h0;
    tick(12);
    arst_n_in <= 1'b1;
    rd(A_MASK, 32'h0000_0000);
    chk({30'h0, irq, sleep}, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    wr(A_MASK, 32'h0000_00FF);
    rd(A_MASK, 32'h0000_00FF);
    wr(A_MASK, 32'h0000_0000);
    rd(A_MASK, 32'h0000_0000);
    wr(A_DATA, 32'h0000_00A5);
    tick(2);
    chk({23'h0, tx_full, tx_byte}, 32'h0000_01A5);
    rd(A_STAT, 32'h0000_000A);
    push(8'h11, 3'h0);
    push(8'h22, 3'h0);
    push(8'h33, 3'h0);
    chk_irq(1'b0);
    rd(A_IDENT, 32'(uden_pkg::ID_NONE));
    wr(A_MASK, 32'h0000_0001);
    chk_irq(1'b1);
    rd(A_DATA, 32'h0000_0011);
    rd(A_DATA, 32'h0000_0022);
    rd(A_DATA, 32'h0000_0033);
    chk_irq(1'b0);
    push(8'h44, 3'h0);
    rd(A_IDENT, 32'(uden_pkg::ID_RXDATA));
    tick(uden_pkg::TOUT_CYC + 100);
    rd(A_IDENT, 32'(uden_pkg::ID_TOUT));
    rd(A_DATA, 32'h0000_0044);
    rd(A_IDENT, 32'(uden_pkg::ID_NONE));
    wr(A_MASK, 32'h0000_0002);
    pulse(1);
    chk_irq(1'b1);
    wr(A_DATA, 32'h0000_003C);
    chk_irq(1'b0);
    pulse(1);
    chk_irq(1'b1);
    rd(A_IDENT, 32'(uden_pkg::ID_TXEMPTY));
    chk_irq(1'b0);
    wr(A_MASK, 32'h0000_0008);
    modem <= 1'b1;
    chk_irq(1'b1);
    modem <= 1'b0;
    chk_irq(1'b0);
    wr(A_MASK, 32'h0000_0000);
    pulse(0);
    chk_irq(1'b0);
    rd(A_LINE, 32'h0000_0002);
    wr(A_MASK, 32'h0000_0004);
    pulse(0);
    chk_irq(1'b1);
    rd(A_LINE, 32'h0000_0002);
    chk_irq(1'b0);
    push(8'h55, 3'h1);
    chk_irq(1'b0);
    rd(A_DATA, 32'h0000_0055);
    chk_irq(1'b1);
    rd(A_LINE, 32'h0000_0004);
    wr(A_MASK, 32'h0000_00F0);
    pulse(2);
    chk_irq(1'b0);
    chk({31'h0, sleep}, 32'h0);
    rd(A_IDENT, 32'(uden_pkg::ID_NONE));
    wr(A_ENH, 32'h0000_0010);
    chk_irq(1'b0);
    chk({31'h0, sleep}, 32'h1);
    // xoff, rts and cts edges each raise and clear in turn
    for (int i = 2; i < 5; i++)
    begin
      pulse(i);
      chk_irq(1'b1);
      rd(A_IDENT, (i == 2) ? 32'(uden_pkg::ID_XOFF) : 32'(uden_pkg::ID_FLOW));
      rts <= 1'b0;
      cts <= 1'b0;
      chk_irq(1'b0);
    end
    wr(A_MASK, 32'h0000_0000);
    tick(2);
    chk({31'h0, sleep}, 32'h0);
    // fill past the 16-byte depth: the seventeenth byte is dropped
    for (int i = 0; i < 17; i++)
      push(8'h60 + 8'(i), 3'h0);
    rd(A_STAT, 32'h0000_0004);
    for (int i = 0; i < 16; i++)
      rd(A_DATA, 32'h0000_0060 + 32'(i));
    rd(A_STAT, 32'h0000_0002);
    wr(A_MASK, 32'h0000_00AA);
    @(posedge clock_in);
    arst_n_in <= 1'b0;
    tick(3);
    arst_n_in <= 1'b1;
    chk({24'h0, tx_byte}, 32'h0000_003C);
    rd(A_MASK, 32'h0000_0000);
    rd(A_DATA, 32'h0000_006B);
    results();
  end
endmodule

// file: verification/uden_host.sv
// uden_host: apb master model of the host processor on the register bus
// assumes a slave that answers by raising pready for one cycle, any number of cycles later
`timescale 1ns/1ps
module uden_host
(
  input wire logic clock_in,
  input wire logic [31:0] prdata_in,
  input wire logic pready_in,
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [4:0] paddr_out,
  output logic [31:0] pwdata_out
);
  // -------------------------------------------------------------
  // idle bus at time zero
  // -------------------------------------------------------------
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 5'h00;
    pwdata_out = 32'h0000_0000;
  end
  // one transfer: setup cycle, access held until pready seen at an edge
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock_in);
    psel_out <= 1'b1;
    penable_out <= 1'b0;
    pwrite_out <= wr;
    paddr_out <= a;
    pwdata_out <= wr ? d : 32'hFFFF_FFFF; // junk on reads
    @(posedge clock_in);
    penable_out <= 1'b1;
    do @(posedge clock_in); while (pready_in !== 1'b1);
    q = prdata_in; // taken at the answering edge
    psel_out <= 1'b0;
    penable_out <= 1'b0;
  endtask
endmodule
